// [hdl/iefp_pkg.sv]
// package: register map, field positions and reset values of the block
package iefp_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_MAIN = 8'h00; // main control
  localparam logic [7:0] ADDR_EDGE_PRIO = 8'h04; // edge and priority
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h08; // external control
  localparam logic [7:0] ADDR_PERIPH_FLAGS = 8'h0c; // peripheral flags
  localparam logic [7:0] ADDR_PRIO_MODE = 8'h10; // priority mode select
  localparam logic [7:0] ADDR_STATUS = 8'h14; // request / vector status

  // ----------------------------------------------------------------
  // main control fields
  // ----------------------------------------------------------------
  localparam int MAIN_GATE_HI = 7;
  localparam int MAIN_GATE_LO = 6;
  localparam int MAIN_T0_EN = 5;
  localparam int MAIN_EXT0_EN = 4;
  localparam int MAIN_PCH_EN = 3;
  localparam int MAIN_T0_FLAG = 2;
  localparam int MAIN_EXT0_FLAG = 1;
  localparam int MAIN_PCH_FLAG = 0;

  // ----------------------------------------------------------------
  // edge / priority fields
  // ----------------------------------------------------------------
  localparam int EP_PULLUP_DIS = 7;
  localparam int EP_EDGE0 = 6; // edges 0..3 at bits 6..3
  localparam int EP_T0_PRIO = 2;
  localparam int EP_EXT3_PRIO = 1;
  localparam int EP_PCH_PRIO = 0;

  // ----------------------------------------------------------------
  // external control fields
  // ----------------------------------------------------------------
  localparam int EX_EXT2_PRIO = 7;
  localparam int EX_EXT1_PRIO = 6;
  localparam int EX_EN3 = 5; // enables 3..1 at bits 5..3
  localparam int EX_FLAG3 = 2; // flags 3..1 at bits 2..0

  // ----------------------------------------------------------------
  // peripheral flag fields
  // ----------------------------------------------------------------
  localparam int PF_PAR = 7;
  localparam int PF_ADC = 6;
  localparam int PF_RX1 = 5;
  localparam int PF_TX1 = 4;
  localparam int PF_SSP1 = 3;
  localparam int PF_CCP1 = 2;
  localparam int PF_T2 = 1;
  localparam int PF_T1 = 0;
  localparam logic [7:0] PF_RO_MASK = 8'h30; // serial bits follow units

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
  localparam logic [7:0] RST_EDGE_PRIO = 8'hff;
  localparam logic [7:0] RST_EXT_CTRL = 8'hc0;
  localparam logic [7:0] RST_PERIPH = 8'h00;

  // ----------------------------------------------------------------
  // vectors and bus answers
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW = 16'h0018;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // event inputs from peripherals and pins
  typedef struct packed {
    logic timer0_ovf;
    logic [3:0] ext_pin; // external interrupt pins 3..0
    logic [3:0] port_b_hi; // port b pins 7..4
    logic par_access;
    logic adc_done;
    logic rx1_full;
    logic tx1_empty;
    logic ssp1_done;
    logic ccp1_event;
    logic timer2_match;
    logic timer1_ovf;
  } iefp_event_type;

  // request towards the core
  typedef struct packed {
    logic req;
    logic high;
    logic [15:0] vector;
  } iefp_core_req_type;

endpackage : iefp_pkg

// [hdl/iefp_ctrl.sv]
// interrupt enable, flag and priority block with an axi4-lite slave
`timescale 1ns/10ps

// Behaviour
// - compat mode: top bit gates every interrupt
// - priority mode: top bit gates high level
// - compat mode: second bit gates peripheral sources
// - priority mode: second bit gates low level
// - per-source enable bits, one enables
// - timer0 overflow sets sticky flag
// - selected pin edge sets external flags
// - port b upper mismatch sets change flag
// - mismatch keeps flag set until port read
// - edge selects bits 6..3, reset to one
// - priority bits, one means high
// - pullup disable bit overrides port latches
// - flags set regardless of enables
// - parallel port access sets flag
// - conversion done sets converter flag
// - receive flag mirrors full rx buffer
// - transmit flag mirrors empty tx buffer
// - sync serial completion sets flag
// - capture or compare event sets flag
// - timer2 period match sets flag
// - timer1 overflow sets flag
// - priority mode bit, default off
// - vector 0008h high, 0018h low
// - request needs flag, enable and gate
// - core acknowledge clears the used gate
module iefp_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral and pin events
  input wire iefp_pkg::iefp_event_type events,
  input wire logic port_b_read,
  input wire logic [1:0] ccp1_mode,
  // core side
  input wire logic core_ack,
  output iefp_pkg::iefp_core_req_type core_req,
  // port b pull-up control
  input wire logic [7:0] port_b_latch,
  output logic [7:0] pullup_en
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] main_r; // main control
  logic [7:0] edge_prio_r; // edge and priority control
  logic [7:0] ext_r; // external control
  logic [7:0] pflag_r; // writable peripheral flags
  logic priority_mode_select_r; // priority mode enable
  logic [3:0] ext_pin_r; // last pin levels for edge finding
  logic [3:0] port_b_last_r; // port b latched at last read
  logic port_b_primed_r; // last state valid after first read
  logic awt_r; // write address taken
  logic wt_r; // write data taken
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic bvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic rvalid_r;
  logic core_req_r;
  logic core_high_r;

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // edge match per pin: one picks rising, zero falling
  wire [3:0] edge_sel = edge_prio_r[iefp_pkg::EP_EDGE0 -: 4];
  wire [3:0] ext_sel = {edge_sel[0], edge_sel[1], edge_sel[2], edge_sel[3]};
  wire [3:0] ext_rise = events.ext_pin & ~ext_pin_r;
  wire [3:0] ext_fall = ~events.ext_pin & ext_pin_r;
  wire [3:0] ext_hit = (ext_sel & ext_rise) | (~ext_sel & ext_fall);
  // mismatch stays as long as pins differ from last read
  wire port_mismatch = port_b_primed_r &&
    (events.port_b_hi != port_b_last_r);
  // capture/compare flag silent in pwm mode (mode 2'b11)
  wire ccp1_hit = events.ccp1_event && (ccp1_mode != 2'b11);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire wr_go = awt_r && wt_r && !bvalid_r;
  wire rd_go = s_axi_arvalid && !rvalid_r;
  wire wr_main = wr_go && awaddr_r == iefp_pkg::ADDR_CTRL_MAIN && wstrb_r[0];
  wire wr_ep = wr_go && awaddr_r == iefp_pkg::ADDR_EDGE_PRIO && wstrb_r[0];
  wire wr_ext = wr_go && awaddr_r == iefp_pkg::ADDR_EXT_CTRL && wstrb_r[0];
  wire wr_pf = wr_go && awaddr_r == iefp_pkg::ADDR_PERIPH_FLAGS &&
    wstrb_r[0];
  wire wr_pm = wr_go && awaddr_r == iefp_pkg::ADDR_PRIO_MODE && wstrb_r[0];
  wire [7:0] wbyte = wdata_r[7:0];

  // address is mapped when it names one of the six words
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = a == iefp_pkg::ADDR_CTRL_MAIN ||
      a == iefp_pkg::ADDR_EDGE_PRIO || a == iefp_pkg::ADDR_EXT_CTRL ||
      a == iefp_pkg::ADDR_PERIPH_FLAGS || a == iefp_pkg::ADDR_PRIO_MODE ||
      a == iefp_pkg::ADDR_STATUS;
  endfunction : addr_ok

  // ----------------------------------------------------------------
  // flag set and clear (set wins over a same-cycle write)
  // ----------------------------------------------------------------
  wire [7:0] main_set = {5'b0, events.timer0_ovf, ext_hit[0],
    port_mismatch};
  wire [7:0] main_nxt = (wr_main ? wbyte : main_r) | main_set;
  wire [7:0] ext_set = {5'b0, ext_hit[3], ext_hit[2], ext_hit[1]};
  wire [7:0] ext_nxt = (wr_ext ? wbyte : ext_r) | ext_set;
  wire [7:0] pf_set = {events.par_access, events.adc_done, 2'b00,
    events.ssp1_done, ccp1_hit, events.timer2_match,
    events.timer1_ovf};
  wire [7:0] pf_nxt = ((wr_pf ? wbyte : pflag_r) | pf_set) &
    ~iefp_pkg::PF_RO_MASK;
  // serial bits are live status of the unit, not stored here
  wire [7:0] pflags = pflag_r | {2'b00, events.rx1_full,
    events.tx1_empty, 4'b0};

  // ----------------------------------------------------------------
  // request generation
  // ----------------------------------------------------------------
  // core sources: timer0, ext0..3, port change
  wire [5:0] core_act = {
    main_r[iefp_pkg::MAIN_T0_FLAG] & main_r[iefp_pkg::MAIN_T0_EN],
    main_r[iefp_pkg::MAIN_EXT0_FLAG] & main_r[iefp_pkg::MAIN_EXT0_EN],
    main_r[iefp_pkg::MAIN_PCH_FLAG] & main_r[iefp_pkg::MAIN_PCH_EN],
    ext_r[2:0] & ext_r[iefp_pkg::EX_EN3 -: 3]};
  // ext0 has no priority bit and is always high
  wire [5:0] core_prio = {edge_prio_r[iefp_pkg::EP_T0_PRIO], 1'b1,
    edge_prio_r[iefp_pkg::EP_PCH_PRIO], edge_prio_r[iefp_pkg::EP_EXT3_PRIO],
    ext_r[iefp_pkg::EX_EXT2_PRIO], ext_r[iefp_pkg::EX_EXT1_PRIO]};
  // peripheral enables live outside; every flag counts at low level
  wire periph_act = |pflags;
  wire gate_hi = main_r[iefp_pkg::MAIN_GATE_HI];
  wire gate_lo = main_r[iefp_pkg::MAIN_GATE_LO];
  // compat: top gate over all, second gate over peripherals
  wire compat_req = gate_hi && ((|core_act) ||
    (gate_lo && periph_act));
  // priority mode: top gate opens high level, both gates open low level
  wire hi_req = gate_hi && (|(core_act & core_prio));
  // low level also needs the top gate: top gate low blocks everything
  wire lo_req = gate_hi && gate_lo && ((|(core_act & ~core_prio)) ||
    periph_act);
  wire req_any = priority_mode_select_r ? (hi_req || lo_req) :
    compat_req;
  wire req_high = !priority_mode_select_r || hi_req;

  // ----------------------------------------------------------------
  // flag and control registers
  // ----------------------------------------------------------------
  // gate cleared on acknowledge, after any software write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      main_r <= iefp_pkg::RST_CTRL_MAIN;
    end else if (core_ack && core_req_r) begin
      main_r <= main_nxt & ~((core_high_r ? 8'h80 : 8'h40));
    end else begin
      main_r <= main_nxt;
    end
  end

  // edge / priority, external control and peripheral flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_prio_r <= iefp_pkg::RST_EDGE_PRIO;
      ext_r <= iefp_pkg::RST_EXT_CTRL;
      pflag_r <= iefp_pkg::RST_PERIPH;
    end else begin
      if (wr_ep) begin
        edge_prio_r <= wbyte;
      end
      ext_r <= ext_nxt;
      pflag_r <= pf_nxt;
    end
  end

  // priority mode bit, off by default
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      priority_mode_select_r <= 1'b0;
    end else if (wr_pm) begin
      priority_mode_select_r <= wbyte[0];
    end
  end

  // pin history for edge finding and port b read latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_pin_r <= 4'h0;
      port_b_last_r <= 4'h0;
      port_b_primed_r <= 1'b0;
    end else begin
      ext_pin_r <= events.ext_pin;
      if (port_b_read) begin
        port_b_last_r <= events.port_b_hi;
        port_b_primed_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // core request, registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_req_r <= 1'b0;
      core_high_r <= 1'b0;
    end else begin
      core_req_r <= req_any && !(core_ack && core_req_r);
      core_high_r <= req_high;
    end
  end

  assign core_req.req = core_req_r;
  assign core_req.high = core_high_r;
  assign core_req.vector = core_high_r ? iefp_pkg::VEC_HIGH :
    iefp_pkg::VEC_LOW;

  // pull-ups: one in the disable bit forces all off
  assign pullup_en = edge_prio_r[iefp_pkg::EP_PULLUP_DIS] ? 8'h00 :
    port_b_latch;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data latched independently, either order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awt_r <= 1'b0;
      wt_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awt_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        awt_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wt_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        wt_r <= 1'b0;
      end
    end
  end

  // write response, slverr on unmapped or read-only address
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= iefp_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (addr_ok(awaddr_r) && awaddr_r != iefp_pkg::ADDR_STATUS) ?
        iefp_pkg::RESP_OKAY : iefp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !awt_r;
  assign s_axi_wready = !wt_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire [7:0] status_byte = {5'b0, core_high_r, core_req_r, req_any};
  logic [7:0] rd_byte;
  always_comb begin
    case (s_axi_araddr)
      iefp_pkg::ADDR_CTRL_MAIN: rd_byte = main_r;
      iefp_pkg::ADDR_EDGE_PRIO: rd_byte = edge_prio_r;
      iefp_pkg::ADDR_EXT_CTRL: rd_byte = ext_r;
      iefp_pkg::ADDR_PERIPH_FLAGS: rd_byte = pflags;
      iefp_pkg::ADDR_PRIO_MODE: rd_byte = {7'b0, priority_mode_select_r};
      iefp_pkg::ADDR_STATUS: rd_byte = status_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  // one-cycle read answer, held until rready
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= iefp_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= addr_ok(s_axi_araddr) ? iefp_pkg::RESP_OKAY :
        iefp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : iefp_ctrl

// [testbench/iefp_ctrl_chk.sv]
// checker: port-level assertions of the interrupt block
`timescale 1ns/10ps
module iefp_ctrl_chk (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side and pull-ups
  input wire logic core_ack,
  input wire iefp_pkg::iefp_core_req_type core_req,
  input wire logic [7:0] port_b_latch,
  input wire logic [7:0] pullup_en
);
  // ------------------------------------------------------------
  // one clock domain, reset disables everything
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_vec; // vector follows the level of the request
    core_req.vector == (core_req.high ? iefp_pkg::VEC_HIGH
                                      : iefp_pkg::VEC_LOW);
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_ack; // taken request is withdrawn next edge
    core_req.req && core_ack |=> !core_req.req;
  endproperty
  a_ack: assert property (p_ack) else $error("req kept");
  property p_pull; // either all off or the port latches
    pullup_en == 8'h00 || pullup_en == port_b_latch;
  endproperty
  a_pull: assert property (p_pull) else $error("pullup wrong");
  // ------------------------------------------------------------
  // bus answers: timing and holding
  // ------------------------------------------------------------
  property p_blat; // taken at one edge, register at next, answer after
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("no bvalid");
  property p_bstand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bstand: assert property (p_bstand) else $error("bvalid drop");
  property p_rstand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rstand: assert property (p_rstand) else $error("rvalid drop");
  property p_arblk; // no new read while data waits
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("arready high");
  property p_slverr; // unmapped read answers error and zero
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14 |=>
      s_axi_rvalid && s_axi_rresp == iefp_pkg::RESP_SLVERR
      && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_slverr: assert property (p_slverr) else $error("no slverr");
endmodule : iefp_ctrl_chk

bind iefp_ctrl iefp_ctrl_chk chk_u (.clk, .arst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_ack,
  .core_req, .port_b_latch, .pullup_en);

// [testbench/iefp_core_model.sv]
// partner model: processor core taking vectored requests
`timescale 1ns/10ps
module iefp_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // request in, acknowledge out
  input wire iefp_pkg::iefp_core_req_type core_req,
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  output logic core_ack
);
  logic [3:0] wait_r; // cycles a request has stood
  // ack once the request stood ack_dly cycles; slow core uses large dly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      core_ack <= ack_en && core_req.req && wait_r == ack_dly;
      wait_r <= (core_req.req && !core_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule : iefp_core_model

// [testbench/interrupt_enable_flag_priority_tb.sv]
// testbench: interrupt enable, flag and priority block
`timescale 1ns/10ps
module interrupt_enable_flag_priority_tb;
  // ------------------------------------------------------------
  // signals, named as the ports they drive
  // ------------------------------------------------------------
  localparam logic [7:0] AM = iefp_pkg::ADDR_CTRL_MAIN;
  localparam logic [7:0] AE = iefp_pkg::ADDR_EDGE_PRIO;
  localparam logic [7:0] AX = iefp_pkg::ADDR_EXT_CTRL;
  localparam logic [7:0] AP = iefp_pkg::ADDR_PERIPH_FLAGS;
  localparam logic [1:0] OK = iefp_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = iefp_pkg::RESP_SLVERR;
  logic clk = 1'b0;
  logic arst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_b_latch, pullup_en;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, ack_dly;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, port_b_read, ack_en, core_ack;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ccp1_mode;
  iefp_pkg::iefp_event_type events, t0m;
  iefp_pkg::iefp_core_req_type core_req;
  int mismatches = 0;
  int num_checks = 0;

  always #4 clk = ~clk; // 125 MHz

  iefp_ctrl dut_u (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events, .port_b_read,
    .ccp1_mode, .core_ack, .core_req, .port_b_latch, .pullup_en);
  iefp_core_model core_u (.clk, .arst_n, .core_req, .ack_en, .ack_dly,
    .core_ack);

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // write: ready sampled mid-cycle, so release lands right after the edge
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (50) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        check("bresp", 32'(s_axi_bresp), 32'(er));
        return;
      end
    end
    mismatches++;
    close_out();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (50) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    mismatches++;
    close_out();
  endtask : rd
  task automatic rdc(input logic [7:0] a, e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check("rdata", d, 32'(e));
    check("rresp", 32'(r), 32'(OK));
  endtask : rdc
  task automatic wait_req(input logic e); // bounded wait on request
    repeat (20) begin
      @(negedge clk);
      if (core_req.req === e) return;
    end
    mismatches++;
    close_out();
  endtask : wait_req
  task automatic no_req;
    repeat (4) @(negedge clk);
    check("req", 32'(core_req.req), 32'h0000_0000);
  endtask : no_req
  task automatic ack; // let the core take the request
    ack_en <= 1'b1;
    wait_req(1'b0);
    ack_en <= 1'b0;
  endtask : ack
  task automatic pulse(input iefp_pkg::iefp_event_type m);
    @(posedge clk);
    events <= events | m;
    @(posedge clk);
    events <= events & ~m;
  endtask : pulse
  task automatic req_is(input logic h, input logic [15:0] v);
    check("high", 32'(core_req.high), 32'(h));
    check("vector", 32'(core_req.vector), 32'(v));
  endtask : req_is

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_reset;
    logic [31:0] d;
    logic [1:0] r;
    rdc(AM, 8'h00);
    rdc(AE, 8'hff);
    rdc(AX, 8'hc0);
    rdc(AP, 8'h00);
    rdc(iefp_pkg::ADDR_PRIO_MODE, 8'h00);
    rd(8'h40, d, r);
    check("unmapped", 32'(r), 32'(ERR));
    wr(iefp_pkg::ADDR_STATUS, 8'hff, ERR);
    check("pullup", 32'(pullup_en), 32'h0000_0000);
  endtask : s_reset
  task automatic s_flags; // every source fires with all enables off
    @(posedge clk);
    port_b_read <= 1'b1;
    @(posedge clk);
    port_b_read <= 1'b0;
    ccp1_mode <= 2'b11;
    events <= '{ext_pin: 4'hf, port_b_hi: 4'h1, default: 1'b1};
    @(posedge clk);
    events <= '{ext_pin: 4'hf, port_b_hi: 4'h1, rx1_full: 1'b1,
                tx1_empty: 1'b1, default: 1'b0};
    rdc(AM, 8'h07);
    rdc(AX, 8'hc7);
    rdc(AP, 8'hfb);
    ccp1_mode <= 2'b00;
    pulse('{ccp1_event: 1'b1, default: '0});
    rdc(AP, 8'hff);
    wr(AP, 8'h00, OK);
    rdc(AP, 8'h30);
    events.rx1_full <= 1'b0;
    events.tx1_empty <= 1'b0;
    rdc(AP, 8'h00);
    wr(AM, 8'h00, OK);
    rdc(AM, 8'h01);
    port_b_read <= 1'b1;
    @(posedge clk);
    port_b_read <= 1'b0;
    wr(AM, 8'h00, OK);
    rdc(AM, 8'h00);
    wr(AX, 8'hc0, OK);
  endtask : s_flags
  task automatic s_edge; // falling edges, then pull-ups on
    wr(AE, 8'h87, OK);
    events.ext_pin <= 4'h0;
    rdc(AM, 8'h02);
    rdc(AX, 8'hc7);
    wr(AE, 8'h07, OK);
    check("pullup", 32'(pullup_en), 32'(port_b_latch));
    wr(AM, 8'h00, OK);
    wr(AX, 8'hc0, OK);
  endtask : s_edge
  task automatic s_compat; // priority mode off
    wr(AM, 8'h20, OK);
    pulse(t0m);
    no_req();
    wr(AM, 8'ha4, OK);
    wait_req(1'b1);
    rdc(iefp_pkg::ADDR_STATUS, 8'h07);
    req_is(1'b1, iefp_pkg::VEC_HIGH);
    ack();
    rdc(AM, 8'h24);
    wr(AM, 8'h00, OK);
    pulse('{adc_done: 1'b1, default: '0});
    wr(AM, 8'h80, OK);
    no_req();
    wr(AM, 8'hc0, OK);
    wait_req(1'b1);
    ack();
    rdc(AM, 8'h40);
    wr(AP, 8'h00, OK);
    wr(AM, 8'h00, OK);
  endtask : s_compat
  task automatic s_prio; // priority mode on, slow core
    ack_dly <= 4'h5;
    wr(iefp_pkg::ADDR_PRIO_MODE, 8'h01, OK);
    wr(AE, 8'h03, OK);
    wr(AM, 8'ha0, OK);
    pulse(t0m);
    no_req();
    wr(AM, 8'h64, OK);
    no_req();
    wr(AM, 8'he4, OK);
    wait_req(1'b1);
    req_is(1'b0, iefp_pkg::VEC_LOW);
    ack();
    rdc(AM, 8'ha4);
    wr(AM, 8'h64, OK);
    wr(AE, 8'h07, OK);
    no_req();
    wr(AM, 8'ha4, OK);
    wait_req(1'b1);
    req_is(1'b1, iefp_pkg::VEC_HIGH);
    ack();
    rdc(AM, 8'h24);
    wr(AM, 8'h00, OK);
  endtask : s_prio
  task automatic s_race; // event lands on the clearing write
    fork
      wr(AP, 8'h00, OK);
      begin
        repeat (2) @(posedge clk);
        events.adc_done <= 1'b1;
        @(posedge clk);
        events.adc_done <= 1'b0;
      end
    join
    rdc(AP, 8'h40);
  endtask : s_race

  // main sequence: reset held ten cycles
  initial begin
    arst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, port_b_read, ack_en} = '0;
    s_axi_wstrb = 4'h1;
    ack_dly = 4'h1;
    ccp1_mode = 2'b00;
    port_b_latch = 8'ha5;
    events = '0;
    t0m = '{timer0_ovf: 1'b1, default: '0};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    s_reset();
    s_flags();
    s_edge();
    s_compat();
    s_prio();
    s_race();
    close_out();
  end
endmodule : interrupt_enable_flag_priority_tb
